//--- bench/tec_event_src.sv
// tec_event_src: model of the external event source on the event pins
`timescale 1ns/10ps

module tec_event_src (
   input wire logic clk_in, // system clock, used for pacing only
   output logic [1:0] pin_out // event pin levels, always driven
);
   // pins start low; the source drives them at all times, so no float
   initial begin
      pin_out = 2'b00;
   end

   // one level change, then a quiet span; a short span is a prompt source,
   // a long one a slow source, both must be seen by the edge filter
   task automatic step(input int ch, input int quiet);
      @(posedge clk_in);
      pin_out[ch] <= ~pin_out[ch];
      repeat (quiet) @(posedge clk_in);
   endtask : step
endmodule : tec_event_src

//--- bench/tec_timer_tb_top.sv
// tec_timer_tb_top: self-checking bench of the two timer channels
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
 $display("unexpected at %0t got %h expected %h", $time, (a), (e)); end end

module tec_timer_tb_top
   import tec_pkg::*;
;
   logic clk_in = 1'b0; // 125 MHz bench clock
   logic nrst_in = 1'b0; // reset, active low
   logic hsel = 1'b0; // bus request fields, driven after rising edges
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] ext_tick = 2'b00; // tick train for select code 7
   int tick_cnt = 0; // tick spacing counter
   tec_ahb_req_type req; // packed request
   tec_ahb_rsp_type rsp; // packed answer
   wire [1:0] ev; // event pins from the source model
   logic [1:0] pin; // timer pins
   logic [1:0] irq; // match pulses
   int num_errors = 0;
   int n_checks = 0;
   int irq_cnt[2] = '{0, 0}; // running match pulse counts

   // the one slave's ready is the bus ready
   assign req = {hsel, haddr, htrans, hwrite, hsize, hwdata, rsp.hreadyout};

   tec_timer i_tec_timer (.clk_in(clk_in), .nrst_in(nrst_in), .ahb_in(req),
      .ahb_out(rsp), .event_input_pin_in(ev), .ext_tick_in(ext_tick),
      .timer_output_pin_out(pin), .match_interrupt_out(irq));
   tec_event_src i_tec_event_src (.clk_in(clk_in), .pin_out(ev));

   // free-running clock, 8 ns period
   initial begin
      forever #4 clk_in = ~clk_in;
   end

   // one tick every fifth cycle on both channels
   always @(posedge clk_in) begin
      tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
      ext_tick <= {2{tick_cnt == 4}};
   end

   // match pulses counted on the falling edge, where they are settled
   always @(negedge clk_in) begin
      for (int c = 0; c < 2; c++) if (irq[c] === 1'b1) irq_cnt[c]++;
   end

   // 0,1 select the match pulses, 2,3 the timer pins
   function automatic logic probe(input int w);
      return (w < 2) ? irq[w] : pin[w - 2];
   endfunction : probe

   // one single word transfer; waits on ready at each phase
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_in);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_in); while (rsp.hreadyout !== 1'b1);
      q = rsp.hrdata;
   endtask : bus

   task automatic wr(input int ch, input logic [7:0] ofs, input int d);
      logic [31:0] q;
      bus(1'b1, 32'(ch * 16 + ofs), 32'(d), q);
   endtask : wr

   task automatic rd(input int ch, input logic [7:0] ofs,
                     output logic [31:0] q);
      bus(1'b0, 32'(ch * 16 + ofs), 32'h0, q);
   endtask : rd

   // cycles between two rising edges of a probed signal
   task automatic gap(input int w, output int n);
      do @(negedge clk_in); while (probe(w) !== 1'b0);
      do @(negedge clk_in); while (probe(w) !== 1'b1);
      n = 0;
      do begin @(negedge clk_in); n++; end while (probe(w) !== 1'b0);
      do begin @(negedge clk_in); n++; end while (probe(w) !== 1'b1);
   endtask : gap

   // high cycles of a probed signal over a span
   task automatic highs(input int w, input int span, output int n);
      n = 0;
      repeat (span) begin
         @(negedge clk_in);
         if (probe(w) === 1'b1) n++;
      end
   endtask : highs

   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // cuts a hang short well beyond the expected run length
   initial begin
      repeat (60000) @(posedge clk_in);
      num_errors++;
      results();
   end

   // main sequence; expectations come from integer models of the rules
   initial begin
      logic [31:0] q;
      int n, nv, b, p;
      int dv[6]; // divisor of codes 2 to 7
      dv = '{1, 2, 4, 64, 256, 5};
      void'($urandom(32'hE756));
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(negedge clk_in);
      `CHK(pin, 2'b00)
      // register access: read back, read-only counter, unmapped place
      wr(0, TEC_OFS_CMP, 8'h5A);
      rd(0, TEC_OFS_CMP, q);
      `CHK(q, 32'h5A)
      wr(0, TEC_OFS_MODE, 8'h13);
      rd(0, TEC_OFS_MODE, q);
      `CHK(q, 32'h03)
      wr(0, TEC_OFS_MODE, 8'h00);
      wr(0, TEC_OFS_CNT, 8'hFF);
      rd(0, TEC_OFS_CNT, q);
      `CHK(q, 32'h0)
      bus(1'b0, 32'h20, 32'h0, q);
      `CHK(q, 32'h0)
      // interval timer over every internal and chained clock choice
      for (int s = 0; s < 6; s++) begin
         nv = (s > 2) ? $urandom_range(0, 2) : $urandom_range(1, 30);
         wr(0, TEC_OFS_CLKSEL, s + 2);
         wr(0, TEC_OFS_CMP, nv);
         wr(0, TEC_OFS_MODE, 8'h00);
         wr(0, TEC_OFS_MODE, 8'h80);
         gap(0, n);
         `CHK(n, dv[s] * (nv + 1))
         wr(0, TEC_OFS_MODE, 8'h00);
      end
      // event counting, falling then rising edges, compare 3
      for (int s = 0; s < 2; s++) begin
         wr(1, TEC_OFS_CLKSEL, s);
         wr(1, TEC_OFS_CMP, 3);
         wr(1, TEC_OFS_MODE, 8'h00);
         if (ev[1] === 1'b1) i_tec_event_src.step(1, 8);
         wr(1, TEC_OFS_MODE, 8'h80);
         b = irq_cnt[1];
         for (int k = 0; k < 7; k++) i_tec_event_src.step(1, 6 + 6 * (k % 2));
         repeat (8) @(posedge clk_in);
         nv = (s == 1) ? 4 : 3; // valid edges among the seven changes
         rd(1, TEC_OFS_CNT, q);
         `CHK(q, 32'(nv % 4))
         `CHK(irq_cnt[1] - b, nv / 4)
         wr(1, TEC_OFS_MODE, 8'h00);
      end
      // square wave on channel 0
      nv = $urandom_range(2, 20);
      wr(0, TEC_OFS_CLKSEL, 2);
      wr(0, TEC_OFS_CMP, nv);
      wr(0, TEC_OFS_MODE, 8'h02);
      wr(0, TEC_OFS_MODE, 8'h03);
      wr(0, TEC_OFS_MODE, 8'h0B);
      repeat (3) @(negedge clk_in);
      `CHK(pin[0], 1'b1)
      wr(0, TEC_OFS_MODE, 8'h8B);
      gap(2, n);
      `CHK(n, 2 * (nv + 1))
      highs(2, 4 * (nv + 1), n);
      `CHK(n, 2 * (nv + 1))
      // stopped with the ff set but the output disabled: pin must stay low
      wr(0, TEC_OFS_MODE, 8'h0A);
      repeat (3) @(negedge clk_in);
      `CHK(pin[0], 1'b0)
      wr(0, TEC_OFS_MODE, 8'h00);
      // pwm on channel 1, high then low active level
      for (int s = 0; s < 2; s++) begin
         nv = $urandom_range(1, 200);
         p = s * 2;
         wr(1, TEC_OFS_CLKSEL, 2);
         wr(1, TEC_OFS_CMP, nv);
         wr(1, TEC_OFS_MODE, 8'h41 + p);
         wr(1, TEC_OFS_MODE, 8'hC1 + p);
         highs(3, 200, n);
         `CHK(n, s * 200)
         gap(3, n);
         `CHK(n, 256)
         highs(3, 256, n);
         `CHK(n, (s == 1) ? 256 - nv : nv)
         gap(1, n);
         `CHK(n, 256)
         wr(1, TEC_OFS_MODE, 8'h41 + p);
         repeat (3) @(posedge clk_in);
         highs(3, 4, n);
         `CHK(n, s * 4)
         wr(1, TEC_OFS_MODE, 8'h00);
      end
      // cascade: 16-bit compare, channel 1 clock choice ignored
      nv = 256 + $urandom_range(0, 40);
      wr(0, TEC_OFS_CLKSEL, 2);
      wr(1, TEC_OFS_CLKSEL, 6);
      wr(0, TEC_OFS_CMP, nv % 256);
      wr(1, TEC_OFS_CMP, nv / 256);
      wr(1, TEC_OFS_MODE, 8'h10);
      wr(1, TEC_OFS_MODE, 8'h90);
      b = irq_cnt[1];
      wr(0, TEC_OFS_MODE, 8'h80);
      gap(0, n);
      `CHK(n, nv + 1)
      `CHK(irq_cnt[1] - b, 0)
      wr(0, TEC_OFS_MODE, 8'h00);
      rd(1, TEC_OFS_CNT, q);
      `CHK(q, 32'h0)
      wr(1, TEC_OFS_MODE, 8'h00);
      results();
   end
endmodule : tec_timer_tb_top

//--- pkg/tec_pkg.sv
// tec_pkg: constants, field layout and carrier types of the timer channels
package tec_pkg;

   // register map, byte offsets inside one channel window
   localparam logic [7:0] TEC_OFS_CLKSEL = 8'h00; // count clock select
   localparam logic [7:0] TEC_OFS_MODE = 8'h04; // channel mode control
   localparam logic [7:0] TEC_OFS_CMP = 8'h08; // compare value
   localparam logic [7:0] TEC_OFS_CNT = 8'h0C; // counter, read only
   localparam logic [7:0] TEC_CH_STRIDE = 8'h10; // distance of channel 1

   // mode control bit positions
   localparam int TEC_BIT_RUN = 7; // count run bit
   localparam int TEC_BIT_PWM = 6; // pwm mode select
   localparam int TEC_BIT_CASC = 4; // cascade join select, channel 1 only
   localparam int TEC_BIT_SET = 3; // output ff set bit
   localparam int TEC_BIT_CLR = 2; // output ff clear bit
   localparam int TEC_BIT_POL = 1; // invert or polarity bit
   localparam int TEC_BIT_OE = 0; // output drive enable

   // reset values and the counter top
   localparam logic [7:0] TEC_RST_CLKSEL = 8'h00; // falling event edge
   localparam logic [7:0] TEC_RST_CMP = 8'h00; // compare value
   localparam logic [7:0] TEC_CNT_TOP = 8'hFF; // last count before wrap

   // count clock select codes
   localparam logic [2:0] TEC_SEL_FALL = 3'h0; // falling event edge
   localparam logic [2:0] TEC_SEL_RISE = 3'h1; // rising event edge
   localparam logic [2:0] TEC_SEL_DIV1 = 3'h2; // system clock
   localparam logic [2:0] TEC_SEL_DIV2 = 3'h3; // system clock / 2
   localparam logic [2:0] TEC_SEL_DIV4 = 3'h4; // system clock / 4
   localparam logic [2:0] TEC_SEL_DIV64 = 3'h5; // system clock / 64
   localparam logic [2:0] TEC_SEL_DIV256 = 3'h6; // system clock / 256
   localparam logic [2:0] TEC_SEL_EXT = 3'h7; // tick from another timer

   // prescaler terminal values for the divided clocks
   localparam logic [7:0] TEC_PRE_DIV2 = 8'h01; // low bit mask /2
   localparam logic [7:0] TEC_PRE_DIV4 = 8'h03; // low bit mask /4
   localparam logic [7:0] TEC_PRE_DIV64 = 8'h3F; // low bit mask /64
   localparam logic [7:0] TEC_PRE_DIV256 = 8'hFF; // low bit mask /256

   // stored part of one channel's mode control
   typedef struct packed {
      logic run; // count run bit
      logic pwm; // pwm mode select
      logic casc; // cascade join select
      logic pol; // invert or polarity bit
      logic oe; // output drive enable
   } tec_mode_type;

   // ahb-lite request from the master
   typedef struct packed {
      logic hsel; // slave select
      logic [31:0] haddr; // byte address
      logic [1:0] htrans; // transfer type
      logic hwrite; // write when high
      logic [2:0] hsize; // transfer size
      logic [31:0] hwdata; // write data, data phase
      logic hready; // bus ready
   } tec_ahb_req_type;

   // ahb-lite answer to the master
   typedef struct packed {
      logic [31:0] hrdata; // read data
      logic hreadyout; // slave ready
      logic hresp; // response, always okay
   } tec_ahb_rsp_type;

endpackage : tec_pkg

//--- src/tec_timer.sv
// tec_timer: two 8-bit timer/event counter channels with cascade and bus
//
// Overview of operation
// - clear-and-start match clears counter, raises interrupt
// - interval timer interrupt every N+1 count clocks
// - event counter increments on each selected edge
// - select 00H falling edge, 01H rising edge
// - event match after N+1 edges, then clear
// - square wave toggles output ff each match
// - square wave frequency is 1/(2t(N+1))
// - pwm output inactive until first overflow
// - overflow drives active level until match
// - pwm match drives inactive until next overflow
// - clearing run forces pwm output inactive
// - pwm period 256, active width N
// - cascade bit joins channels into 16 bits
// - low compare low byte, high compare high
// - cascade match raises low interrupt, clears both
// - cascade uses low channel clock select only
// - polarity bit: pwm active level, else inversion
// - output disabled holds timer pin low
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps

module tec_timer
   import tec_pkg::*;
(
   input wire logic clk_in, // 125 MHz system clock
   input wire logic nrst_in, // asynchronous reset, active low
   input wire tec_ahb_req_type ahb_in, // ahb-lite request
   output tec_ahb_rsp_type ahb_out, // ahb-lite answer
   input wire logic [1:0] event_input_pin_in, // external event pins
   input wire logic [1:0] ext_tick_in, // same-clock ticks, select 7
   output logic [1:0] timer_output_pin_out, // timer output pins
   output logic [1:0] match_interrupt_out // one-cycle match pulses
);

   // channel state
   logic [1:0][2:0] sel_q; // count clock select per channel
   tec_mode_type [1:0] mode_q; // mode control per channel
   logic [1:0][7:0] cmp_q; // compare value per channel
   logic [1:0][7:0] cnt_q; // counter per channel
   logic [1:0] ff_q; // output flip-flop per channel
   logic [1:0] pin_q; // registered timer pins
   logic [1:0] irq_q; // registered match pulses
   logic [7:0] pre_q; // free prescaler

   // event input conditioning, three stages per pin
   logic [1:0] sync1_q; // first stage, only read by the second
   logic [1:0] sync2_q; // second stage
   logic [1:0] sync3_q; // third stage
   logic [1:0] evlvl_q; // accepted event level

   // bus state
   logic wr_pend_q; // write data phase pending
   logic [7:0] wr_addr_q; // address of pending write
   logic [31:0] rdata_q; // read data for the data phase

   // combinational terms
   logic [1:0] rise; // accepted rising edges
   logic [1:0] fall; // accepted falling edges
   logic [1:0] tick; // count clock per channel
   logic [1:0] stop; // counter held clear
   logic [1:0] pwm_on; // channel really in pwm mode
   logic [1:0] hit; // clear-and-start match
   logic [1:0] pwm_hit; // pwm compare match
   logic [1:0] pwm_ovf; // pwm overflow
   logic casc; // channels joined
   logic match16; // 16-bit compare equal
   logic [7:0] wbyte; // write data low byte
   logic rd_ch; // channel named by the bus address phase
   logic [1:0] wr_mode; // mode register written this cycle

   // pick the count clock from a select code
   function automatic logic sel_tick(input logic [2:0] sel,
                                     input logic [7:0] pre,
                                     input logic r,
                                     input logic f,
                                     input logic x);
      logic t;
      t = 1'b0;
      case (sel)
         TEC_SEL_FALL: t = f;
         TEC_SEL_RISE: t = r;
         TEC_SEL_DIV1: t = 1'b1;
         TEC_SEL_DIV2: t = (pre & TEC_PRE_DIV2) == TEC_PRE_DIV2;
         TEC_SEL_DIV4: t = (pre & TEC_PRE_DIV4) == TEC_PRE_DIV4;
         TEC_SEL_DIV64: t = (pre & TEC_PRE_DIV64) == TEC_PRE_DIV64;
         TEC_SEL_DIV256: t = pre == TEC_PRE_DIV256;
         TEC_SEL_EXT: t = x;
         default: t = 1'b0;
      endcase
      return t;
   endfunction : sel_tick

   // map a byte address onto the channel it addresses
   function automatic logic addr_ch(input logic [7:0] a);
      return a[7:0] >= TEC_CH_STRIDE;
   endfunction : addr_ch

   // register offset inside the channel window
   function automatic logic [7:0] addr_ofs(input logic [7:0] a);
      return a & (TEC_CH_STRIDE - 8'h01);
   endfunction : addr_ofs

   // free prescaler feeds the divided count clocks
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pre_q <= 8'h00;
      end else begin
         pre_q <= pre_q + 8'h01;
      end
   end

   // event pins: a change counts once stages two and three agree
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
         sync3_q <= 2'h0;
         evlvl_q <= 2'h0;
      end else begin
         sync1_q <= event_input_pin_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 2; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
               evlvl_q[i] <= sync3_q[i];
            end
         end
      end
   end

   // count clocks, matches and overflows
   always_comb begin
      wbyte = ahb_in.hwdata[7:0];
      rd_ch = addr_ch(ahb_in.haddr[7:0]);
      casc = mode_q[1].casc;
      match16 = {cnt_q[1], cnt_q[0]} == {cmp_q[1], cmp_q[0]};
      for (int i = 0; i < 2; i++) begin
         rise[i] = (sync2_q[i] == sync3_q[i]) && sync3_q[i] && !evlvl_q[i];
         fall[i] = (sync2_q[i] == sync3_q[i]) && !sync3_q[i] && evlvl_q[i];
      end
      // count clock of channel 0 (event edge, divided clock or tick) chosen by select code
      tick[0] = sel_tick(sel_q[0], pre_q, rise[0], fall[0],
                         ext_tick_in[0]);
      // in cascade the high half runs off the low half's carry
      if (casc) begin
         tick[1] = tick[0] && mode_q[0].run && !match16
                   && cnt_q[0] == TEC_CNT_TOP;
      end else begin
         tick[1] = sel_tick(sel_q[1], pre_q, rise[1], fall[1],
                            ext_tick_in[1]);
      end
      stop[0] = !mode_q[0].run;
      // stopping the low half also clears the joined high half
      stop[1] = !mode_q[1].run || (casc && !mode_q[0].run);
      pwm_on[0] = mode_q[0].pwm;
      pwm_on[1] = mode_q[1].pwm && !casc;
      for (int i = 0; i < 2; i++) begin
         pwm_ovf[i] = !stop[i] && tick[i] && pwm_on[i]
                      && cnt_q[i] == TEC_CNT_TOP;
         pwm_hit[i] = !stop[i] && tick[i] && pwm_on[i]
                      && cnt_q[i] + 8'h01 == cmp_q[i];
      end
      if (casc) begin
         hit[0] = !stop[0] && tick[0] && match16;
         hit[1] = hit[0];
      end else begin
         for (int i = 0; i < 2; i++) begin
            hit[i] = !stop[i] && tick[i] && !pwm_on[i]
                     && cnt_q[i] == cmp_q[i];
         end
      end
      for (int i = 0; i < 2; i++) begin
         wr_mode[i] = wr_pend_q && addr_ofs(wr_addr_q) == TEC_OFS_MODE
                      && addr_ch(wr_addr_q) == i[0];
      end
   end

   // counters: cleared when stopped, on a match, else count
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_q <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (stop[i] || hit[i]) begin
               cnt_q[i] <= 8'h00;
            end else if (tick[i]) begin
               cnt_q[i] <= cnt_q[i] + 8'h01;
            end
         end
      end
   end

   // match pulses; the joined high half never raises its own
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_q <= 2'h0;
      end else begin
         irq_q[0] <= hit[0] || pwm_hit[0];
         irq_q[1] <= !casc && (hit[1] || pwm_hit[1]);
      end
   end

   // output flip-flops: set/clear by write, toggle or pwm shaping
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ff_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (pwm_on[i]) begin
               // stopped pwm sits at the inactive level
               if (stop[i] || pwm_hit[i]) begin
                  ff_q[i] <= 1'b0;
               end else if (pwm_ovf[i]) begin
                  ff_q[i] <= 1'b1;
               end
            end else if (wr_mode[i] && wbyte[TEC_BIT_SET]) begin
               ff_q[i] <= 1'b1; // set bit wins over a match toggle
            end else if (wr_mode[i] && wbyte[TEC_BIT_CLR]) begin
               ff_q[i] <= 1'b0;
            end else if (hit[i] && mode_q[i].pol && !(casc && i == 1)) begin
               ff_q[i] <= !ff_q[i];
            end
         end
      end
   end

   // pins: low when disabled, polarity applied in pwm mode
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!mode_q[i].oe) begin
               pin_q[i] <= 1'b0;
            end else if (pwm_on[i]) begin
               pin_q[i] <= ff_q[i] ^ mode_q[i].pol;
            end else begin
               pin_q[i] <= ff_q[i];
            end
         end
      end
   end

   // bus: capture the address phase, no wait states
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready
                      && ahb_in.hwrite;
         wr_addr_q <= ahb_in.haddr[7:0];
      end
   end

   // read data is prepared at the address phase edge; upper bits zero
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= 32'h0000_0000;
      end else if (ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready
                   && !ahb_in.hwrite) begin
         rdata_q <= 32'h0000_0000;
         // an address beyond both windows reads as zero
         if (ahb_in.haddr[31:5] == 27'h0) begin
            case (addr_ofs(ahb_in.haddr[7:0]))
               TEC_OFS_CLKSEL: rdata_q[2:0] <= sel_q[rd_ch];
               TEC_OFS_MODE: begin
                  // set and clear bits always read as zero
                  rdata_q[TEC_BIT_RUN] <= mode_q[rd_ch].run;
                  rdata_q[TEC_BIT_PWM] <= mode_q[rd_ch].pwm;
                  rdata_q[TEC_BIT_CASC] <= mode_q[rd_ch].casc;
                  rdata_q[TEC_BIT_POL] <= mode_q[rd_ch].pol;
                  rdata_q[TEC_BIT_OE] <= mode_q[rd_ch].oe;
               end
               TEC_OFS_CMP: rdata_q[7:0] <= cmp_q[rd_ch];
               TEC_OFS_CNT: rdata_q[7:0] <= cnt_q[rd_ch];
               default: rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // register writes in the data phase; only the low address byte is decoded, and writes whose low byte is 20H or more
   // are dropped except for the set and clear bits at offset 04H, which still act on ff_q[1]
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sel_q <= {TEC_RST_CLKSEL[2:0], TEC_RST_CLKSEL[2:0]};
         mode_q <= '0;
         cmp_q <= {TEC_RST_CMP, TEC_RST_CMP};
      end else if (wr_pend_q && wr_addr_q < (TEC_CH_STRIDE << 1)) begin
         case (addr_ofs(wr_addr_q))
            TEC_OFS_CLKSEL: sel_q[addr_ch(wr_addr_q)] <= wbyte[2:0];
            TEC_OFS_MODE: begin
               mode_q[addr_ch(wr_addr_q)].run <= wbyte[TEC_BIT_RUN];
               mode_q[addr_ch(wr_addr_q)].pwm <= wbyte[TEC_BIT_PWM];
               // the join bit exists only in channel 1
               mode_q[addr_ch(wr_addr_q)].casc <= wbyte[TEC_BIT_CASC]
                                                  && addr_ch(wr_addr_q);
               mode_q[addr_ch(wr_addr_q)].pol <= wbyte[TEC_BIT_POL];
               mode_q[addr_ch(wr_addr_q)].oe <= wbyte[TEC_BIT_OE];
            end
            TEC_OFS_CMP: cmp_q[addr_ch(wr_addr_q)] <= wbyte;
            default: ;
         endcase
      end
   end

   // outputs straight from flip-flops, ready and response tied off; the slave never stalls
   assign ahb_out.hrdata = rdata_q;
   assign ahb_out.hreadyout = 1'b1;
   assign ahb_out.hresp = 1'b0;
   assign timer_output_pin_out = pin_q;
   assign match_interrupt_out = irq_q;

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   a_match_clears: assert property (
      hit[0] |=> cnt_q[0] == 8'h00 && match_interrupt_out[0])
      else $error("match did not clear counter and pulse");
   a_irq_has_cause: assert property (
      match_interrupt_out[0] |-> $past(tick[0]) && !$past(stop[0]))
      else $error("match pulse without a count clock");
   a_event_counts: assert property (
      !stop[0] && !casc && tick[0] && !hit[0] |=>
      cnt_q[0] == $past(cnt_q[0]) + 8'h01)
      else $error("counter missed a count");
   a_edge_select: assert property (
      sel_q[1] == TEC_SEL_FALL && !casc |->
      tick[1] == (evlvl_q[1] && !sync2_q[1] && !sync3_q[1]))
      else $error("falling select not obeyed");
   a_square_toggle: assert property (
      hit[0] && !pwm_on[0] && mode_q[0].pol && !wr_mode[0] |=>
      ff_q[0] != $past(ff_q[0]))
      else $error("output ff not inverted on match");
   a_pwm_overflow: assert property (
      pwm_ovf[1] && !pwm_hit[1] |=> ff_q[1])
      else $error("overflow did not go active");
   a_pwm_match: assert property (
      pwm_hit[1] |=> !ff_q[1] ##0 match_interrupt_out[1])
      else $error("pwm match did not go inactive");
   a_pwm_stopped: assert property (
      pwm_on[1] && stop[1] ##1 pwm_on[1] && stop[1] |=>
      timer_output_pin_out[1] == $past(mode_q[1].oe & mode_q[1].pol))
      else $error("stopped pwm output not inactive");
   a_oe_low: assert property (
      !mode_q[1].oe |=> !timer_output_pin_out[1])
      else $error("disabled output not low");
   a_cascade_carry: assert property (
      casc && !stop[1] && tick[0] && !hit[0] && cnt_q[0] == 8'hFF |=>
      cnt_q[1] == $past(cnt_q[1]) + 8'h01 && cnt_q[0] == 8'h00)
      else $error("high half missed the carry");
   a_cascade_irq: assert property (
      casc |=> !match_interrupt_out[1])
      else $error("high channel pulsed while joined");

endmodule : tec_timer
